//--- atd_pkg.sv
package atd_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_TRIG_DELAY_CONTROL_OFS = 8'h08;
  localparam logic [7:0] SOURCE_SELECTION_CONTROL_OFS = 8'h0C;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 7;

  // ----------------------------------------------------------------
  // Field positions, auxiliary trigger delay control
  // ----------------------------------------------------------------
  localparam int TAP_LSB = 0;
  localparam int TAP_W = 9;
  localparam int TAP_LOAD_BIT = 9;
  localparam int INT_DLY_LSB = 12;
  localparam int INT_DLY_W = 2;

  // ----------------------------------------------------------------
  // Field positions, source selection control
  // ----------------------------------------------------------------
  localparam int SYNC_MASTER_BIT = 0;
  localparam int CLK_MASTER_BIT = 1;
  localparam int GATE_DRV_LSB = 16;
  localparam int SYNC_DRV_LSB = 20;
  localparam int LED_SRC_LSB = 24;
  localparam int SEL_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [TAP_W-1:0] TAP_RST = 9'h000;
  localparam logic TAP_LOAD_RST = 1'b0;
  localparam logic [INT_DLY_W-1:0] INT_DLY_RST = 2'h0;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;

  // ----------------------------------------------------------------
  // Indicator lamp source codes
  // ----------------------------------------------------------------
  typedef enum logic [SEL_W-1:0] {
    LED_OFF = 3'h0,
    LED_GATE_IN = 3'h1,
    LED_SYNC_IN = 3'h2,
    LED_PPS_IN = 3'h3,
    LED_GATE_BUS = 3'h4,
    LED_SYNC_BUS = 3'h5,
    LED_USER_A = 3'h6,
    LED_USER_B = 3'h7
  } atd_led_src_t;

  // ----------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TAP_W-1:0] tap;
    logic tap_load;
    logic [INT_DLY_W-1:0] int_dly;
    logic [SEL_W-1:0] led_src;
    logic [SEL_W-1:0] sync_drv;
    logic [SEL_W-1:0] gate_drv;
    logic sync_master;
    logic clk_master;
    logic load_strobe;
    logic wr_aux;
    logic wr_src;
    logic [31:0] rdata;
    logic sync1;
    logic sync2;
    logic sync3;
    logic trig_filt;
    logic [2:0] dly;
    logic trig_out;
    logic led;
  } atd_state_t;

endpackage

//--- atd_aux_trig_ctrl.sv
`timescale 1ns/1ns
module atd_aux_trig_ctrl
(
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HWDATA_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Input delay element
  output logic [8:0] TAP_VALUE_OUT,
  output logic TAP_LOAD_OUT,
  input wire logic AUX_TRIG_TAPPED_IN,
  output logic AUX_TRIG_OUT,
  // Lamp sources, same clock
  input wire logic GATE_SEL_IN,
  input wire logic SYNC_SEL_IN,
  input wire logic PPS_SEL_IN,
  input wire logic GATE_BUS_IN,
  input wire logic SYNC_BUS_IN,
  input wire logic USER_PPS_IN,
  output logic LED_OUT,
  // Drive selects and master controls
  output logic [2:0] SYNC_DRV_SEL_OUT,
  output logic [2:0] GATE_DRV_SEL_OUT,
  output logic SYNC_MASTER_OUT,
  output logic CLK_MASTER_OUT
);

  atd_pkg::atd_state_t st;
  atd_pkg::atd_state_t next_st;
  logic take;
  logic [7:0] addr_lo;

  // ----------------------------------------------------------------
  // Register read images
  // ----------------------------------------------------------------
  function automatic logic [31:0] aux_image(input atd_pkg::atd_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[atd_pkg::TAP_LSB +: atd_pkg::TAP_W] = s.tap;
    w[atd_pkg::TAP_LOAD_BIT] = s.tap_load;
    w[atd_pkg::INT_DLY_LSB +: atd_pkg::INT_DLY_W] = s.int_dly;
    return w;
  endfunction

  function automatic logic [31:0] src_image(input atd_pkg::atd_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[atd_pkg::SYNC_MASTER_BIT] = s.sync_master;
    w[atd_pkg::CLK_MASTER_BIT] = s.clk_master;
    w[atd_pkg::GATE_DRV_LSB +: atd_pkg::SEL_W] = s.gate_drv;
    w[atd_pkg::SYNC_DRV_LSB +: atd_pkg::SEL_W] = s.sync_drv;
    w[atd_pkg::LED_SRC_LSB +: atd_pkg::SEL_W] = s.led_src;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  // Only NONSEQ/SEQ with the bus ready counts; idle and busy are ignored
  assign take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  assign addr_lo = HADDR_IN[7:0];

  // Next state of the whole block
  always_comb
  begin
    next_st = st;
    // Data phase of a write: whole word taken whatever HSIZE_IN says, always zero wait
    if (st.wr_aux)
    begin
      next_st.tap = HWDATA_IN[atd_pkg::TAP_LSB +: atd_pkg::TAP_W];
      next_st.tap_load = HWDATA_IN[atd_pkg::TAP_LOAD_BIT];
      next_st.int_dly = HWDATA_IN[atd_pkg::INT_DLY_LSB +: atd_pkg::INT_DLY_W];
    end
    if (st.wr_src)
    begin
      next_st.led_src = HWDATA_IN[atd_pkg::LED_SRC_LSB +: atd_pkg::SEL_W];
      next_st.sync_drv = HWDATA_IN[atd_pkg::SYNC_DRV_LSB +: atd_pkg::SEL_W];
      next_st.gate_drv = HWDATA_IN[atd_pkg::GATE_DRV_LSB +: atd_pkg::SEL_W];
      next_st.sync_master = HWDATA_IN[atd_pkg::SYNC_MASTER_BIT];
      next_st.clk_master = HWDATA_IN[atd_pkg::CLK_MASTER_BIT];
    end
    // Falling load bit fires the element once; a held level does nothing
    next_st.load_strobe = st.tap_load & ~next_st.tap_load;
    // Capture the new transfer; read image taken after any write lands
    next_st.wr_aux = take & HWRITE_IN & (addr_lo == atd_pkg::AUX_TRIG_DELAY_CONTROL_OFS);
    next_st.wr_src = take & HWRITE_IN & (addr_lo == atd_pkg::SOURCE_SELECTION_CONTROL_OFS);
    next_st.rdata = 32'h0000_0000;
    if (take & ~HWRITE_IN)
    begin
      if (addr_lo == atd_pkg::AUX_TRIG_DELAY_CONTROL_OFS)
      begin
        next_st.rdata = aux_image(next_st);
      end
      else if (addr_lo == atd_pkg::SOURCE_SELECTION_CONTROL_OFS)
      begin
        next_st.rdata = src_image(next_st);
      end
    end
    // Pin synchroniser; a change counts once stages two and three agree
    next_st.sync1 = AUX_TRIG_TAPPED_IN;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    if (st.sync2 == st.sync3)
    begin
      next_st.trig_filt = st.sync3;
    end
    // Whole-cycle delay after the tap stage
    next_st.dly = {st.dly[1:0], st.trig_filt};
    unique case (st.int_dly)
      2'h0: next_st.trig_out = st.trig_filt;
      2'h1: next_st.trig_out = st.dly[0];
      2'h2: next_st.trig_out = st.dly[1];
      2'h3: next_st.trig_out = st.dly[2];
    endcase
    // Lamp source select
    unique case (atd_pkg::atd_led_src_t'(st.led_src))
      atd_pkg::LED_OFF: next_st.led = 1'b0;
      atd_pkg::LED_GATE_IN: next_st.led = GATE_SEL_IN;
      atd_pkg::LED_SYNC_IN: next_st.led = SYNC_SEL_IN;
      atd_pkg::LED_PPS_IN: next_st.led = PPS_SEL_IN;
      atd_pkg::LED_GATE_BUS: next_st.led = GATE_BUS_IN;
      atd_pkg::LED_SYNC_BUS: next_st.led = SYNC_BUS_IN;
      atd_pkg::LED_USER_A, atd_pkg::LED_USER_B: next_st.led = USER_PPS_IN;
    endcase
  end

  // State register; constants only under reset
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      st <= '0;
      st.tap <= atd_pkg::TAP_RST;
      st.tap_load <= atd_pkg::TAP_LOAD_RST;
      st.int_dly <= atd_pkg::INT_DLY_RST;
      st.led_src <= atd_pkg::SEL_RST;
      st.sync_drv <= atd_pkg::SEL_RST;
      st.gate_drv <= atd_pkg::SEL_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // No wait states, so the slave is always ready and always OKAY
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = st.rdata;
  assign TAP_VALUE_OUT = st.tap;
  assign TAP_LOAD_OUT = st.load_strobe;
  assign AUX_TRIG_OUT = st.trig_out;
  assign LED_OUT = st.led;
  assign SYNC_DRV_SEL_OUT = st.sync_drv;
  assign GATE_DRV_SEL_OUT = st.gate_drv;
  assign SYNC_MASTER_OUT = st.sync_master;
  assign CLK_MASTER_OUT = st.clk_master;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  sequence s_load_toggle;
    st.tap_load ##1 !st.tap_load;
  endsequence

  property p_int_dly0;
    $past(st.int_dly) == 2'h0 |-> st.trig_out == $past(st.trig_filt);
  endproperty
  a_int_dly0: assert property (p_int_dly0) else $error("delay 0 wrong");

  property p_int_dly3;
    $past(st.int_dly) == 2'h3 |-> st.trig_out == $past(st.trig_filt, 4);
  endproperty
  a_int_dly3: assert property (p_int_dly3) else $error("delay 3 wrong");

  property p_tap_write;
    st.wr_aux |=> TAP_VALUE_OUT == $past(HWDATA_IN[8:0]);
  endproperty
  a_tap_write: assert property (p_tap_write) else $error("tap not written");

  property p_load;
    s_load_toggle |-> TAP_LOAD_OUT;
  endproperty
  a_load: assert property (p_load) else $error("load strobe missing");

  property p_one_shot;
    TAP_LOAD_OUT |=> !TAP_LOAD_OUT;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("strobe too long");

  property p_no_spur;
    TAP_LOAD_OUT |-> $past(st.tap_load) && !st.tap_load;
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("spurious strobe");

  property p_led_off;
    $past(st.led_src) == 3'h0 |-> !LED_OUT;
  endproperty
  a_led_off: assert property (p_led_off) else $error("lamp not off");

  property p_led_gate;
    $past(st.led_src) == 3'h1 |-> LED_OUT == $past(GATE_SEL_IN);
  endproperty
  a_led_gate: assert property (p_led_gate) else $error("lamp not gate");

  property p_led_user;
    $past(st.led_src[2:1]) == 2'h3 |-> LED_OUT == $past(USER_PPS_IN);
  endproperty
  a_led_user: assert property (p_led_user) else $error("lamp not user pps");

  property p_master;
    st.wr_src |=> SYNC_MASTER_OUT == $past(HWDATA_IN[0]) && CLK_MASTER_OUT == $past(HWDATA_IN[1]);
  endproperty
  a_master: assert property (p_master) else $error("master bits wrong");

endmodule

//--- atd_panel_model.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Front-panel connector and lamp source lines
// ------------------------------------------------
module atd_panel_model
(
  // Commands from the bench
  input wire logic [5:0] lamp_lines_in,
  input wire logic trig_level_in,
  // Lines into the block
  output logic gate_sel_out,
  output logic sync_sel_out,
  output logic pps_sel_out,
  output logic gate_bus_out,
  output logic sync_bus_out,
  output logic user_pps_out,
  output logic trig_tapped_out
);
  // Plain levels; the connector has no timing of its own
  assign {user_pps_out, sync_bus_out, gate_bus_out, pps_sel_out, sync_sel_out, gate_sel_out} =
    lamp_lines_in;
  assign trig_tapped_out = trig_level_in;
endmodule

//--- aux_trigger_delay_and_led_select_tb.sv
`timescale 1ns/1ns
module aux_trigger_delay_and_led_select_tb;
  logic clk, rst_n, hsel, hwrite, trig;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd, hrdata, n_mismatch, cmp_count;
  logic [5:0] lamp;
  logic g_s, s_s, p_s, g_b, s_b, u_p, t_t, ld, led, trig_out, hrdy, hresp, s_m, c_m;
  logic [8:0] tap;
  logic [2:0] sdrv, gdrv;
  int n;
  // ------------------------------------------------
  // Clock, far-side model and the block
  // ------------------------------------------------
  // 125 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  atd_panel_model u_atd_panel_model (.lamp_lines_in(lamp), .trig_level_in(trig),
    .gate_sel_out(g_s), .sync_sel_out(s_s), .pps_sel_out(p_s), .gate_bus_out(g_b),
    .sync_bus_out(s_b), .user_pps_out(u_p), .trig_tapped_out(t_t));
  atd_aux_trig_ctrl u_atd_aux_trig_ctrl (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
    .HREADY_IN(hrdy), .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy),
    .HRESP_OUT(hresp), .TAP_VALUE_OUT(tap), .TAP_LOAD_OUT(ld), .AUX_TRIG_TAPPED_IN(t_t),
    .AUX_TRIG_OUT(trig_out), .GATE_SEL_IN(g_s), .SYNC_SEL_IN(s_s), .PPS_SEL_IN(p_s),
    .GATE_BUS_IN(g_b), .SYNC_BUS_IN(s_b), .USER_PPS_IN(u_p), .LED_OUT(led),
    .SYNC_DRV_SEL_OUT(sdrv), .GATE_DRV_SEL_OUT(gdrv), .SYNC_MASTER_OUT(s_m),
    .CLK_MASTER_OUT(c_m));
  // ------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for hready high at a rising edge; read before that edge's updates
  // land, so it is the value the edge saw; the watchdog ends a hang
  task automatic wait_rdy();
    do
    begin
      @(posedge clk);
    end
    while (hrdy !== 1'b1);
  endtask
  // One single word transfer; starts and ends on a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog, well over ten times the expected run
  initial
  begin
    #40000;
    n_mismatch = n_mismatch + 1;
    final_report();
  end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    {rst_n, hsel, hwrite, trig, htrans, hsize, haddr, hwdata, lamp} = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h0000_000C, 32'h0);
    chk(rd, 32'h0);
    // Reserved bits must read back as zero
    bus(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
    #1;
    chk({31'h0, ld}, 32'h0);
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0000_33FF);
    chk({23'h0, tap}, 32'h1FF);
    // Falling load bit gives one pulse only
    bus(1'b1, 32'h0000_0008, 32'h0000_0155);
    #1;
    chk({31'h0, ld}, 32'h1);
    chk({23'h0, tap}, 32'h155);
    @(posedge clk);
    #1;
    chk({31'h0, ld}, 32'h0);
    bus(1'b1, 32'h0000_0008, 32'h0000_0155);
    #1;
    chk({31'h0, ld}, 32'h0);
    // Whole-cycle delay after the tap stage, each setting
    for (int d = 0; d < 4; d++)
    begin
      bus(1'b1, 32'h0000_0008, 32'(d) << 12);
      trig <= 1'b0;
      repeat (10) @(posedge clk);
      trig <= 1'b1;
      n = 0;
      while (trig_out !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(32'(n), 32'(5 + d));
    end
    // Unmapped place: write ignored, reads zero
    bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0010, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0000_3000);
    bus(1'b1, 32'h0000_000C, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_000C, 32'h0);
    chk(rd, 32'h0777_0003);
    // Every lamp code: other lines high, then only the chosen one
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 32'h0000_000C, (32'(c) << 24) | 32'h0052_0003);
      #1;
      chk({9'h0, sdrv, 1'b0, gdrv, 14'h0, c_m, s_m}, 32'h0052_0003);
      n = (c > 5) ? 5 : c - 1;
      @(posedge clk);
      lamp <= (c == 0) ? 6'h3F : ~(6'h01 << n);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, led}, 32'h0);
      @(posedge clk);
      lamp <= (c == 0) ? 6'h00 : (6'h01 << n);
      repeat (2) @(posedge clk);
      #1;
      chk({31'h0, led}, {31'h0, c != 0});
    end
    // Reset in mid-run returns both registers to zero
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 32'h0000_000C, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h0000_0008, 32'h0);
    chk(rd, 32'h0);
    final_report();
  end
endmodule
